// File: design/crl_pkg.sv
package crl_pkg;

   // frame geometry, bit positions counted from the tag MSB
   localparam int unsigned POS_W = 8;
   localparam logic [7:0] POS_FIRST = 8'h00;
   localparam logic [7:0] POS_ONE = 8'h01;
   localparam logic [7:0] POS_TAG_LAST = 8'h0F;
   localparam logic [7:0] POS_ADDR_LAST = 8'h1F;
   localparam logic [7:0] POS_DATA16_FIRST = 8'h20;
   localparam logic [7:0] POS_DATA16_LAST = 8'h2F;
   localparam logic [7:0] POS_DATA20_FIRST = 8'h24;
   localparam logic [7:0] POS_DATA20_LAST = 8'h33;
   localparam logic [7:0] POS_FRAME_LAST = 8'hFF;

   // tag slot layout
   localparam int unsigned TAG_FRAME_BIT = 15;
   localparam int unsigned TAG_ADDR_BIT = 14;
   localparam int unsigned TAG_DATA_BIT = 13;
   localparam logic [15:0] WRITE_TAG_WORD = 16'hE000;
   localparam logic [15:0] READ_TAG_WORD = 16'hC000;
   localparam logic [15:0] IDLE_TAG_WORD = 16'h8000;

   // command and status address words
   localparam int unsigned READ_REQ_BIT = 15;
   localparam int unsigned SA_IDX_LSB = 8;
   localparam logic [7:0] SA_LOW_ZERO = 8'h00;

   // indexed register map
   localparam int unsigned IDX_W = 7;
   localparam int unsigned REG_COUNT = 64;
   localparam logic [6:0] IDX_RESET_REG = 7'h00;
   localparam logic [6:0] IDX_SERIAL_CFG = 7'h74;
   localparam logic [6:0] IDX_VENDOR1 = 7'h7C;
   localparam logic [6:0] IDX_VENDOR2 = 7'h7E;
   localparam int unsigned CFG_SIXTEEN_SLOT_MODE_BIT = 15;
   localparam int unsigned CFG_MASK_LSB = 12;
   localparam logic [1:0] CHAIN_LAST = 2'h2;

   // bus side
   localparam int unsigned AV_ADDR_W = 4;
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   localparam logic [3:0] OFS_LAST_CMD = 4'h8;
   localparam logic [3:0] OFS_CMD_COUNT = 4'hC;
   localparam int unsigned CTRL_EN_BIT = 0;
   localparam int unsigned CTRL_POS_LSB = 1;
   localparam logic CTRL_EN_RESET = 1'b1;
   localparam logic [1:0] CTRL_POS_RESET = 2'h0;
   localparam int unsigned EVT_W = 24;

   function automatic logic [15:0] crl_reg_reset(input logic [6:0] idx);
      case (idx)
         7'h00: crl_reg_reset = 16'h0400;
         7'h06, 7'h0A, 7'h20: crl_reg_reset = 16'h8000;
         7'h0C, 7'h0E: crl_reg_reset = 16'h8008;
         7'h10, 7'h12, 7'h14, 7'h16, 7'h18: crl_reg_reset = 16'h8808;
         7'h1A: crl_reg_reset = 16'h0404;
         7'h1C: crl_reg_reset = 16'h0F0F;
         7'h74: crl_reg_reset = 16'hFF80;
         7'h78, 7'h7A: crl_reg_reset = 16'hBB80;
         default: crl_reg_reset = 16'h0000;
      endcase
   endfunction : crl_reg_reset

endpackage : crl_pkg

// File: design/crl_top.sv
module crl_top
   import crl_pkg::*;
#(
   parameter logic [15:0] VENDOR_ID1 = 16'h5A01, // arbitrary value
   parameter logic [15:0] VENDOR_ID2 = 16'h0001  // arbitrary value
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [crl_pkg::AV_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic link_clk,
   input wire logic frame_sync,
   input wire logic sdata_in,
   output logic sdata_out
);
   import crl_pkg::*;

   // bus domain state
   logic ctrl_en;
   logic [1:0] ctrl_pos;
   logic [15:0] wr_count;
   logic [15:0] rd_count;
   logic last_rd;
   logic [IDX_W-1:0] last_idx;
   logic [15:0] last_data;
   logic sixteen_slot_mode_meta;
   logic sixteen_slot_mode_sync;
   logic evt_valid_sys;
   logic [EVT_W-1:0] evt_data_sys;
   logic [31:0] next_readdata;

   // link domain state
   logic [1:0] link_rst_pipe;
   logic link_rst_n;
   logic [2:0] cfg_meta;
   logic [2:0] cfg_sync;
   logic [POS_W-1:0] pos;
   logic [POS_W-1:0] cur_pos;
   logic [14:0] rx_shift;
   logic [15:0] rx_word;
   logic [15:0] cap_tag;
   logic [15:0] cap_addr;
   logic [15:0] cap_data;
   logic [15:0] regs [REG_COUNT];
   logic [15:0] tx_tag;
   logic [15:0] tx_addr;
   logic [15:0] tx_data;
   logic next_sdata;

   // decoded command of the frame now ending
   logic link_en;
   logic [1:0] chain_pos;
   logic sixteen_slot_mode;
   logic [2:0] reg_mask;
   logic frame_end;
   logic cmd_present;
   logic is_read;
   logic is_write;
   logic wr_accept;
   logic [IDX_W-1:0] cmd_idx;
   logic [5:0] cmd_slot;
   logic idx_writable;
   logic [15:0] rd_value;
   logic [POS_W-1:0] data_first;
   logic [POS_W-1:0] data_last;
   logic evt_busy;

   // ---------------- bus slave ----------------

   // one wait cycle, then the answer stands for exactly one edge
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= '0;
      end
      else
      begin
         avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
         if (avs_read && avs_waitrequest)
         begin
            avs_readdata <= next_readdata;
         end
      end
   end

   always_comb
   begin
      case (avs_address)
         OFS_CTRL: next_readdata = {29'h0, ctrl_pos, ctrl_en};
         OFS_STATUS: next_readdata = {31'h0, sixteen_slot_mode_sync};
         OFS_LAST_CMD: next_readdata = {8'h0, last_rd, last_idx, last_data};
         OFS_CMD_COUNT: next_readdata = {rd_count, wr_count};
         default: next_readdata = '0;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         ctrl_en <= CTRL_EN_RESET;
         ctrl_pos <= CTRL_POS_RESET;
      end
      else if (avs_write && !avs_waitrequest && avs_address == OFS_CTRL)
      begin
         ctrl_en <= avs_writedata[CTRL_EN_BIT];
         ctrl_pos <= avs_writedata[CTRL_POS_LSB +: 2];
      end
   end

   // command log from the link, one entry per accepted command
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         wr_count <= '0;
         rd_count <= '0;
         last_rd <= 1'b0;
         last_idx <= '0;
         last_data <= '0;
      end
      else if (evt_valid_sys)
      begin
         last_rd <= evt_data_sys[EVT_W-1];
         last_idx <= evt_data_sys[16 +: IDX_W];
         last_data <= evt_data_sys[15:0];
         if (evt_data_sys[EVT_W-1])
         begin
            rd_count <= rd_count + 16'h0001;
         end
         else
         begin
            wr_count <= wr_count + 16'h0001;
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         sixteen_slot_mode_meta <= 1'b0;
         sixteen_slot_mode_sync <= 1'b0;
      end
      else
      begin
         sixteen_slot_mode_meta <= sixteen_slot_mode;
         sixteen_slot_mode_sync <= sixteen_slot_mode_meta;
      end
   end

   crl_word_xfer #(
      .WIDTH(EVT_W)
   ) u_evt_xfer (
      .src_clk(link_clk),
      .src_rst_n(link_rst_n),
      .src_valid(frame_end && (is_read || wr_accept)),
      .src_data({is_read, cmd_idx, is_read ? rd_value : cap_data}),
      .src_busy(evt_busy),
      .dst_clk(sys_clk),
      .dst_rst_n(rst_n),
      .dst_valid(evt_valid_sys),
      .dst_data(evt_data_sys)
   );

   // ---------------- link domain ----------------

   always_ff @(posedge link_clk)
   begin
      link_rst_pipe <= {link_rst_pipe[0], rst_n};
   end
   assign link_rst_n = link_rst_pipe[1];

   // enable and chain position are quasi-static, so per-bit sync is enough
   always_ff @(posedge link_clk)
   begin
      if (!link_rst_n)
      begin
         cfg_meta <= '0;
         cfg_sync <= '0;
      end
      else
      begin
         cfg_meta <= {ctrl_pos, ctrl_en};
         cfg_sync <= cfg_meta;
      end
   end

   assign link_en = cfg_sync[0];
   assign chain_pos = cfg_sync[2:1];
   assign cur_pos = frame_sync ? POS_FIRST : pos;
   assign frame_end = cur_pos == POS_FRAME_LAST;
   assign rx_word = {rx_shift, sdata_in};
   assign sixteen_slot_mode = regs[IDX_SERIAL_CFG[6:1]][CFG_SIXTEEN_SLOT_MODE_BIT];
   assign reg_mask = regs[IDX_SERIAL_CFG[6:1]][CFG_MASK_LSB +: 3];
   assign data_first = sixteen_slot_mode ? POS_DATA16_FIRST : POS_DATA20_FIRST;
   assign data_last = sixteen_slot_mode ? POS_DATA16_LAST : POS_DATA20_LAST;

   always_ff @(posedge link_clk)
   begin
      if (!link_rst_n)
      begin
         pos <= POS_FIRST;
         rx_shift <= '0;
      end
      else
      begin
         pos <= cur_pos + POS_ONE;
         rx_shift <= rx_word[14:0];
      end
   end

   // slot capture; the address word ends at the same bit in both slot widths
   always_ff @(posedge link_clk)
   begin
      if (!link_rst_n)
      begin
         cap_tag <= '0;
         cap_addr <= '0;
         cap_data <= '0;
      end
      else
      begin
         if (cur_pos == POS_TAG_LAST)
         begin
            cap_tag <= rx_word;
         end
         if (cur_pos == POS_ADDR_LAST)
         begin
            cap_addr <= rx_word;
         end
         if (cur_pos == data_last)
         begin
            cap_data <= rx_word;
         end
      end
   end

   assign cmd_present = link_en && cap_tag[TAG_FRAME_BIT] && cap_tag[TAG_ADDR_BIT];
   assign cmd_idx = cap_addr[IDX_W-1:0];
   assign cmd_slot = cmd_idx[6:1];
   assign is_read = cmd_present && cap_addr[READ_REQ_BIT];
   assign is_write = cmd_present && cap_tag[TAG_DATA_BIT] && !cap_addr[READ_REQ_BIT];
   assign idx_writable = cmd_idx != IDX_RESET_REG && cmd_idx != IDX_VENDOR1
      && cmd_idx != IDX_VENDOR2;

   // in sixteen-slot mode chained codecs share one write only where their mask bit allows it; otherwise only chain position 0 takes it
   always_comb
   begin
      if (sixteen_slot_mode)
      begin
         wr_accept = is_write && chain_pos <= CHAIN_LAST && reg_mask[chain_pos];
      end
      else
      begin
         wr_accept = is_write && chain_pos == 2'h0;
      end
   end

   always_comb
   begin
      if (cmd_idx == IDX_VENDOR1)
      begin
         rd_value = VENDOR_ID1;
      end
      else if (cmd_idx == IDX_VENDOR2)
      begin
         rd_value = VENDOR_ID2;
      end
      else
      begin
         rd_value = regs[cmd_slot];
      end
   end

   // indexed registers; the low index bit is ignored, words sit on even indices
   generate
      for (genvar g = 0; g < REG_COUNT; g++)
      begin : g_reg
         always_ff @(posedge link_clk)
         begin
            if (!link_rst_n)
            begin
               regs[g] <= crl_reg_reset(IDX_W'(2 * g));
            end
            else if (frame_end && wr_accept && idx_writable && cmd_slot == 6'(g))
            begin
               regs[g] <= cap_data;
            end
         end
      end
   endgenerate

   // response words for the next frame, loaded as the current one ends
   always_ff @(posedge link_clk)
   begin
      if (!link_rst_n)
      begin
         tx_tag <= IDLE_TAG_WORD;
         tx_addr <= {1'b0, IDX_SERIAL_CFG, SA_LOW_ZERO};
         tx_data <= '0;
      end
      else if (frame_end)
      begin
         tx_tag <= is_read ? READ_TAG_WORD : IDLE_TAG_WORD;
         if (is_read || is_write)
         begin
            tx_addr <= {1'b0, cmd_idx, SA_LOW_ZERO};
         end
         else
         begin
            tx_addr <= {1'b0, IDX_SERIAL_CFG, SA_LOW_ZERO};
         end
         tx_data <= is_read ? rd_value : 16'h0000;
      end
   end

   always_comb
   begin
      next_sdata = 1'b0;
      if (cur_pos <= POS_TAG_LAST)
      begin
         next_sdata = tx_tag[4'(POS_TAG_LAST - cur_pos)];
      end
      else if (cur_pos <= POS_ADDR_LAST)
      begin
         next_sdata = tx_addr[4'(POS_ADDR_LAST - cur_pos)];
      end
      else if (cur_pos >= data_first && cur_pos <= data_last)
      begin
         next_sdata = tx_data[4'(data_last - cur_pos)];
      end
      if (!link_en)
      begin
         next_sdata = 1'b0;
      end
   end

   // output lags the incoming bit by one link clock
   always_ff @(posedge link_clk)
   begin
      if (!link_rst_n)
      begin
         sdata_out <= 1'b0;
      end
      else
      begin
         sdata_out <= next_sdata;
      end
   end

   // ---------------- checks ----------------

   a_bus_wait_one: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer not given one cycle after request");

   a_bus_answer_once: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !avs_waitrequest |=> avs_waitrequest)
      else $error("bus answer held longer than one cycle");

   a_ctrl_write_lands: assert property (@(posedge sys_clk) disable iff (!rst_n)
      avs_write && !avs_waitrequest && avs_address == OFS_CTRL
      |=> ctrl_en == $past(avs_writedata[CTRL_EN_BIT]))
      else $error("control write not stored");

   a_read_echo_idx: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      frame_end && is_read |=> tx_addr[SA_IDX_LSB +: IDX_W] == $past(cmd_idx)
      && tx_tag == READ_TAG_WORD)
      else $error("read response does not echo index");

   a_read_data_next: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      frame_end && is_read |=> tx_data == $past(rd_value) ##1 !frame_end [*8])
      else $error("read data not loaded for the next frame");

   a_idle_shows_cfg: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      frame_end && !is_read && !is_write
      |=> tx_addr[SA_IDX_LSB +: IDX_W] == IDX_SERIAL_CFG && tx_data == 16'h0000)
      else $error("idle frame does not show configuration index");

   a_write_stores: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      frame_end && wr_accept && idx_writable |=> regs[$past(cmd_slot)] == $past(cap_data))
      else $error("accepted write not stored");

   a_read_no_store: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      frame_end && is_read |=> regs[$past(cmd_slot)] == $past(rd_value)
      || !$past(idx_writable))
      else $error("read request changed a register");

   a_mask_blocks: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      frame_end && is_write && !wr_accept |=> $stable(regs[$past(cmd_slot)]))
      else $error("masked codec took a write");

   a_tag_on_wire: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      link_en && cur_pos == POS_FIRST |=> sdata_out == tx_tag[TAG_FRAME_BIT])
      else $error("frame valid bit not on the wire");

endmodule : crl_top

// File: design/crl_word_xfer.sv
// toggle handshake carrying one word from the link domain to the bus domain
module crl_word_xfer #(
   parameter int unsigned WIDTH = 24
) (
   input wire logic src_clk,
   input wire logic src_rst_n,
   input wire logic src_valid,
   input wire logic [WIDTH-1:0] src_data,
   output logic src_busy,
   input wire logic dst_clk,
   input wire logic dst_rst_n,
   output logic dst_valid,
   output logic [WIDTH-1:0] dst_data
);
   logic req_t;
   logic ack_t;
   logic ack_meta;
   logic ack_sync;
   logic req_meta;
   logic req_sync;
   logic req_seen;
   logic [WIDTH-1:0] hold;

   // hold stays put until the ack returns, so the far side may read it directly
   always_ff @(posedge src_clk)
   begin
      if (!src_rst_n)
      begin
         req_t <= 1'b0;
         hold <= '0;
      end
      else if (src_valid && !src_busy)
      begin
         req_t <= ~req_t;
         hold <= src_data;
      end
   end

   always_ff @(posedge src_clk)
   begin
      if (!src_rst_n)
      begin
         ack_meta <= 1'b0;
         ack_sync <= 1'b0;
      end
      else
      begin
         ack_meta <= ack_t;
         ack_sync <= ack_meta;
      end
   end

   assign src_busy = req_t != ack_sync;

   always_ff @(posedge dst_clk)
   begin
      if (!dst_rst_n)
      begin
         req_meta <= 1'b0;
         req_sync <= 1'b0;
         req_seen <= 1'b0;
         ack_t <= 1'b0;
         dst_valid <= 1'b0;
         dst_data <= '0;
      end
      else
      begin
         req_meta <= req_t;
         req_sync <= req_meta;
         req_seen <= req_sync;
         ack_t <= req_sync;
         dst_valid <= req_sync != req_seen;
         if (req_sync != req_seen)
         begin
            dst_data <= hold;
         end
      end
   end

endmodule : crl_word_xfer

// File: verification/crl_host_model.sv
module crl_host_model
   import crl_pkg::*;
(
   output logic link_clk,
   output logic frame_sync,
   output logic sdata_in,
   input wire logic sdata_out
);
   timeunit 1ns;
   timeprecision 100ps;

   // link clock runs free, as a tdm bit clock does; phase unrelated to sys_clk
   initial
   begin
      link_clk = 1'b0;
      frame_sync = 1'b0;
      sdata_in = 1'b0;
      #41;
      forever #62.5 link_clk = ~link_clk;
   end

   // one command per call; calls in a row give back to back frames
   task automatic send_frame(
      input logic [15:0] tag,
      input logic [15:0] addr,
      input logic [15:0] data,
      output logic [15:0] st_tag,
      output logic [15:0] st_addr,
      output logic [15:0] st_data,
      output logic st_ok
   );
      logic [255:0] tx;
      logic [255:0] rx;
      tx = '0;
      tx[255 -: 16] = tag;
      tx[239 -: 16] = addr;
      if (tag[TAG_DATA_BIT])
         tx[223 -: 16] = data;
      rx = '0;
      for (int p = 0; p < 256; p++)
      begin
         @(negedge link_clk);
         frame_sync = (p == 0);
         sdata_in = tx[255 - p];
         @(posedge link_clk);
         // device output lags its input by one bit
         if (p > 0)
            rx[256 - p] = sdata_out;
      end
      st_tag = rx[255 -: 16];
      st_addr = rx[239 -: 16];
      st_data = rx[223 -: 16];
      st_ok = st_tag[TAG_FRAME_BIT] & st_tag[TAG_ADDR_BIT];
   endtask : send_frame

endmodule : crl_host_model

// File: verification/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import crl_pkg::*;

   logic sys_clk;
   logic rst_n;
   logic [AV_ADDR_W-1:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic link_clk;
   logic frame_sync;
   logic sdata_in;
   logic sdata_out;
   logic [15:0] st_tag;
   logic [15:0] st_addr;
   logic [15:0] st_data;
   logic st_ok;
   logic [31:0] rd;
   int n_errors = 0;
   int samples_checked = 0;
   int cycles = 0;

   crl_top crl_top_i (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .link_clk(link_clk),
      .frame_sync(frame_sync),
      .sdata_in(sdata_in),
      .sdata_out(sdata_out)
   );

   crl_host_model crl_host_model_i (
      .link_clk(link_clk),
      .frame_sync(frame_sync),
      .sdata_in(sdata_in),
      .sdata_out(sdata_out)
   );

   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   task automatic finish_test;
      if (n_errors == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : finish_test

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // an edge passes first so a release and the next request never share a step
   task automatic av_xfer(input logic wr, input logic [AV_ADDR_W-1:0] addr,
                          input logic [31:0] wdata, output logic [31:0] rdata);
      @(posedge sys_clk);
      avs_address <= addr;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= wdata;
      do
         @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0);
      rdata = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : av_xfer

   task automatic frame(input logic [15:0] tag, input logic [15:0] addr, input logic [15:0] data);
      crl_host_model_i.send_frame(tag, addr, data, st_tag, st_addr, st_data, st_ok);
   endtask : frame

   // words returned during the frame just sent, answering the frame before it
   task automatic resp(input logic [15:0] tag, input logic [15:0] addr, input logic [15:0] data);
      check({st_tag, st_addr}, {tag, addr});
      check({16'h0000, st_data}, {16'h0000, data});
   endtask : resp

   task automatic sc_bus_reset;
      av_xfer(1'b0, OFS_CTRL, 32'h0000_0000, rd);
      check(rd, 32'h0000_0001);
      av_xfer(1'b0, OFS_STATUS, 32'h0000_0000, rd);
      check(rd, 32'h0000_0001);
      av_xfer(1'b1, 4'h2, 32'hFFFF_FFFF, rd);
      av_xfer(1'b0, 4'h2, 32'h0000_0000, rd);
      check(rd, 32'h0000_0000);
      av_xfer(1'b0, OFS_CTRL, 32'h0000_0000, rd);
      check(rd, 32'h0000_0001);
   endtask : sc_bus_reset

   task automatic sc_write_read;
      frame(WRITE_TAG_WORD, 16'h0002, 16'h1234);
      resp(IDLE_TAG_WORD, {1'b0, IDX_SERIAL_CFG, SA_LOW_ZERO}, 16'h0000);
      frame(READ_TAG_WORD, 16'h8002, 16'h0000);
      resp(IDLE_TAG_WORD, 16'h0200, 16'h0000);
      // read bit set under a write tag must still act as a read
      frame(WRITE_TAG_WORD, 16'h8002, 16'hBEEF);
      resp(READ_TAG_WORD, 16'h0200, 16'h1234);
      frame(WRITE_TAG_WORD, 16'h0000, 16'hFFFF);
      resp(READ_TAG_WORD, 16'h0200, 16'h1234);
      frame(READ_TAG_WORD, 16'h8000, 16'h0000);
   endtask : sc_write_read

   // the first frame here carries the answer to the last read above
   task automatic sc_chain;
      av_xfer(1'b1, OFS_CTRL, 32'h0000_0005, rd);
      frame(WRITE_TAG_WORD, 16'h0006, 16'h5555);
      resp(READ_TAG_WORD, 16'h0000, 16'h0400);
      check({31'h0, st_ok}, 32'h0000_0001);
      frame(READ_TAG_WORD, 16'h8006, 16'h0000);
      // chain position 3 has no mask bit, so this write must be dropped
      av_xfer(1'b1, OFS_CTRL, 32'h0000_0007, rd);
      frame(WRITE_TAG_WORD, 16'h0006, 16'hAAAA);
      resp(READ_TAG_WORD, 16'h0600, 16'h5555);
      av_xfer(1'b1, OFS_CTRL, 32'h0000_0001, rd);
      frame(READ_TAG_WORD, 16'h8006, 16'h0000);
      frame(IDLE_TAG_WORD, 16'h0000, 16'h0000);
      resp(READ_TAG_WORD, 16'h0600, 16'h5555);
   endtask : sc_chain

   task automatic sc_counts;
      av_xfer(1'b0, OFS_CMD_COUNT, 32'h0000_0000, rd);
      check(rd, 32'h0005_0003);
      av_xfer(1'b0, OFS_LAST_CMD, 32'h0000_0000, rd);
      check(rd, 32'h0086_5555);
      av_xfer(1'b0, OFS_CTRL, 32'h0000_0000, rd);
      check(rd, 32'h0000_0001);
   endtask : sc_counts

   // ten frames of 256 link bits are about 80000 cycles; the ceiling leaves margin
   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 90000)
      begin
         n_errors++;
         finish_test;
      end
   end

   initial
   begin
      rst_n = 1'b0;
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      // long enough for the link side reset to see several link edges
      repeat (200) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (100) @(posedge sys_clk);
      sc_bus_reset;
      sc_write_read;
      sc_chain;
      sc_counts;
      finish_test;
   end

endmodule : tb_top
